/* File: src/lds_pkg.sv */
// Constants shared by the low-side diagnosis serial slave
package lds_pkg;
   // Clock rate and channel count
   localparam int CLK_MHZ = 25;
   localparam int NUM_CH  = 4;
   // Channel mode field codes
   localparam logic [1:0] MODE_IDLE   = 2'h0;
   localparam logic [1:0] MODE_DIRECT = 2'h1;
   localparam logic [1:0] MODE_ON     = 2'h2;
   localparam logic [1:0] MODE_OFF    = 2'h3;
   // Reset values of the serial-visible registers
   localparam logic [7:0] INPUT_RST = 8'h00;
   localparam logic [7:0] DIAG_RST  = 8'h00;
   // Field positions: mode of channel n at 2n+1:2n, flags likewise
   localparam int MODE_LSB_STEP = 2;
   localparam int OL_BIT_OFS    = 1;
   localparam int FLT_BIT_OFS   = 0;
   // Timing figures in microseconds and derived cycle counts
   localparam int OL_DELAY_US       = 30;
   localparam int OL_DELAY_MAX_US   = 200;
   localparam int OVL_DELAY_US      = 5;
   localparam int OVL_DELAY_MAX_US  = 60;
   localparam int OL_DELAY_CYC      = OL_DELAY_US * CLK_MHZ;
   localparam int OVL_DELAY_CYC     = OVL_DELAY_US * CLK_MHZ;
   localparam int TMR_W             = 13;
endpackage

/* File: src/lds_spi_slave.sv */
// Serial slave and per-channel diagnosis of a four-channel low-side driver
// Contract
// - Latch overload/overtemperature outcome per channel
// - Idle mode clears flags, disables pull-down
// - Flags stay latched until idle mode
// - Direct mode, input low: filtered open-load
// - Forced-off mode: filtered open-load detection
// - No open-load diagnosis while channel on
// - Overtemperature always checked, switches off, flags; in idle mode the code switches off but sets no flag
// - Persistent overload switches off, sets fault
// - Open-load filtered against short transients
// - Chip select high ignores clock, tristates
// - Sample on falling, shift out rising
// - Words travel most significant bit first
// - Select falling loads diagnosis into shifter
// - Before first rise, output error OR input
// - Any reset sets the transfer error flag
// - Commit only on nonzero multiple of eight
// - One bit per clock; chains clock N*8
// - Reset clears input and diagnosis registers
// - Input register and diagnosis register provided
// - Mode encoding idle, direct, on, off
// - Channel n mode at bits 2n+1:2n
// - Open-load odd bits, fault even bits
// - Overload-shut channel stays off until cleared
module lds_spi_slave (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        arst_n,
   // Serial pins
   input  wire logic                        cs_n,
   input  wire logic                        sclk,
   input  wire logic                        sdi,
   output logic                             sdo,
   output logic                             sdo_oe,
   // Channel pins and analog status
   input  wire logic [lds_pkg::NUM_CH-1:0]  chan_in,
   input  wire logic [lds_pkg::NUM_CH-1:0]  open_load_det,
   input  wire logic [lds_pkg::NUM_CH-1:0]  overload_det,
   input  wire logic [lds_pkg::NUM_CH-1:0]  overtemp_det,
   // Channel outputs
   output logic [lds_pkg::NUM_CH-1:0]       chan_on,
   output logic [lds_pkg::NUM_CH-1:0]       diag_pulldown_current,
   // Register views
   output logic [7:0]                       input_reg_q,
   output logic [7:0]                       diag_reg_q,
   output logic                             transfer_error_flag
);
   import lds_pkg::*;

   // Reset release through two flops
   logic       rst_s1_reg;
   logic       rst_n_reg;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_reg <= 1'b0;
         rst_n_reg  <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n_reg  <= rst_s1_reg;
      end
   end

   // Pin synchronisers: first stage read only by second stage
   localparam int NSYNC = 3 + 3 * NUM_CH + NUM_CH;
   logic [NSYNC-1:0] pin_s1_reg;
   logic [NSYNC-1:0] pin_s2_reg;
   always_ff @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         pin_s1_reg <= {{(NSYNC-3){1'b0}}, 3'h1};
         pin_s2_reg <= {{(NSYNC-3){1'b0}}, 3'h1};
      end else begin
         pin_s1_reg <= {chan_in, open_load_det, overload_det,
                        overtemp_det, sdi, sclk, cs_n};
         pin_s2_reg <= pin_s1_reg;
      end
   end
   logic              cs_n_s;        // Synced chip select
   logic              sclk_s;        // Synced serial clock
   logic              sdi_s;         // Synced data in
   logic [NUM_CH-1:0] ot_s;          // Synced overtemperature
   logic [NUM_CH-1:0] ovl_s;         // Synced overload
   logic [NUM_CH-1:0] ol_s;          // Synced open-load level
   logic [NUM_CH-1:0] in_s;          // Synced input pins
   assign {in_s, ol_s, ovl_s, ot_s, sdi_s, sclk_s, cs_n_s} = pin_s2_reg;

   // Edge history of synced serial signals
   logic cs_d_reg;
   logic sclk_d_reg;
   always_ff @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         cs_d_reg   <= 1'b1;
         sclk_d_reg <= 1'b0;
      end else begin
         cs_d_reg   <= cs_n_s;
         sclk_d_reg <= sclk_s;
      end
   end
   logic cs_fall;                    // Access starts
   logic cs_rise;                    // Access ends
   logic sclk_fall;                  // Sample point
   logic sclk_rise;                  // Shift-out point
   assign cs_fall   = cs_d_reg & ~cs_n_s;
   assign cs_rise   = ~cs_d_reg & cs_n_s;
   // Clock edges only count while selected
   assign sclk_fall = ~cs_n_s & sclk_d_reg & ~sclk_s;
   assign sclk_rise = ~cs_n_s & ~sclk_d_reg & sclk_s;

   // Registers visible over the serial link
   logic [7:0]        shift_reg;     // Single shifter, one bit per clock
   logic [7:0]        in_reg;        // Mode word
   logic [NUM_CH-1:0] flt_reg;       // Latched fault flags
   logic [NUM_CH-1:0] ol_reg;        // Latched open-load flags
   logic [2:0]        bitcnt_reg;    // Clocks modulo eight
   logic              anyclk_reg;    // At least one clock seen
   logic              first_reg;     // No rising edge yet in access
   logic              ter_reg;       // Transfer error flag
   logic              sdo_reg;       // Data out bit
   logic              commit;        // Valid frame end

   // Mode field decode used per channel
   function automatic logic [1:0] mode_of(input logic [7:0] w,
                                          input int ch);
      mode_of = w[MODE_LSB_STEP*ch +: 2];
   endfunction

   // Diagnosis word: open-load odd, fault even
   logic [7:0] diag_word;
   always_comb begin
      diag_word = DIAG_RST;
      for (int i = 0; i < NUM_CH; i++) begin
         diag_word[2*i+OL_BIT_OFS]  = ol_reg[i];
         diag_word[2*i+FLT_BIT_OFS] = flt_reg[i];
      end
   end

   // Frame commits only on a nonzero multiple of eight
   assign commit = cs_rise & anyclk_reg & (bitcnt_reg == 3'h0);

   // Shifter: load diagnosis on select fall, LSB in at sample edge
   always_ff @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         shift_reg <= DIAG_RST;
      end else if (cs_fall) begin
         shift_reg <= diag_word;
      end else if (sclk_fall) begin
         shift_reg <= {shift_reg[6:0], sdi_s};
      end
   end

   // Clock counter modulo eight plus nonzero marker
   always_ff @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         bitcnt_reg <= 3'h0;
         anyclk_reg <= 1'b0;
      end else if (cs_fall) begin
         bitcnt_reg <= 3'h0;
         anyclk_reg <= 1'b0;
      end else if (sclk_fall) begin
         bitcnt_reg <= bitcnt_reg + 3'h1;
         anyclk_reg <= 1'b1;
      end
   end

   // Transfer error: set by reset, updated each finished access
   always_ff @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ter_reg <= 1'b1;
      end else if (cs_rise) begin
         ter_reg <= ~commit;
      end
   end

   // Input register updated only by a valid frame
   always_ff @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         in_reg <= INPUT_RST;
      end else if (commit) begin
         in_reg <= shift_reg;
      end
   end

   // Data out: MSB on first rise onward; before it, error OR input
   always_ff @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         first_reg <= 1'b1;
         sdo_reg   <= 1'b0;
      end else if (cs_n_s) begin
         // Rearmed while deselected, so the first window opens clean
         first_reg <= 1'b1;
         sdo_reg   <= 1'b0;
      end else if (sclk_rise) begin
         first_reg <= 1'b0;
         // Falling sample already moved next bit to MSB
         sdo_reg   <= shift_reg[7];
      end
   end
   // First window tracks input level live, so the chain sees errors
   assign sdo    = first_reg ? (ter_reg | sdi_s) : sdo_reg;
   assign sdo_oe = ~cs_n_s;

   // Per-channel protection and diagnosis
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic [1:0]       mode;
      logic             want_on;
      logic [TMR_W-1:0] ol_cnt_reg;   // Open-load filter timer
      logic [TMR_W-1:0] ovl_cnt_reg;  // Overload persistence timer
      logic             ol_diag;      // Off-state diagnosis allowed
      assign mode    = mode_of(in_reg, c);
      // Direct mode follows pin; forced on; else off
      assign want_on = (mode == MODE_ON) ||
                       (mode == MODE_DIRECT && in_s[c]);
      // Diagnosis only off-state in direct or forced-off
      assign ol_diag = (mode == MODE_OFF) ||
                       (mode == MODE_DIRECT && !in_s[c]);

      // Open-load filter: level must persist the full delay
      always_ff @(posedge clk or negedge rst_n_reg) begin
         if (!rst_n_reg) begin
            ol_cnt_reg <= '0;
         end else if (!ol_diag || !ol_s[c]) begin
            ol_cnt_reg <= '0;
         end else if (ol_cnt_reg != TMR_W'(OL_DELAY_CYC)) begin
            ol_cnt_reg <= ol_cnt_reg + 1'b1;
         end
      end

      // Overload timer runs only while on and overloaded
      always_ff @(posedge clk or negedge rst_n_reg) begin
         if (!rst_n_reg) begin
            ovl_cnt_reg <= '0;
         end else if (!chan_on[c] || !ovl_s[c]) begin
            ovl_cnt_reg <= '0;
         end else if (ovl_cnt_reg != TMR_W'(OVL_DELAY_CYC)) begin
            ovl_cnt_reg <= ovl_cnt_reg + 1'b1;
         end
      end

      // Latched flags; idle clears, else sticky
      always_ff @(posedge clk or negedge rst_n_reg) begin
         if (!rst_n_reg) begin
            flt_reg[c] <= 1'b0;
            ol_reg[c]  <= 1'b0;
         end else if (mode == MODE_IDLE) begin
            flt_reg[c] <= 1'b0;
            ol_reg[c]  <= 1'b0;
         end else begin
            if (ot_s[c] ||
                ovl_cnt_reg == TMR_W'(OVL_DELAY_CYC)) begin
               flt_reg[c] <= 1'b1;
            end
            if (ol_cnt_reg == TMR_W'(OL_DELAY_CYC)) begin
               ol_reg[c] <= 1'b1;
            end
         end
      end

      // Stage output: held off while fault latched or hot
      always_ff @(posedge clk or negedge rst_n_reg) begin
         if (!rst_n_reg) begin
            chan_on[c] <= 1'b0;
         end else begin
            chan_on[c] <= want_on && !flt_reg[c] && !ot_s[c] &&
                          ovl_cnt_reg != TMR_W'(OVL_DELAY_CYC);
         end
      end

      // Pull-down current off only in idle
      always_ff @(posedge clk or negedge rst_n_reg) begin
         if (!rst_n_reg) begin
            diag_pulldown_current[c] <= 1'b0;
         end else begin
            diag_pulldown_current[c] <= (mode != MODE_IDLE);
         end
      end
   end

   // Register views for observation
   assign input_reg_q         = in_reg;
   assign diag_reg_q          = diag_word;
   assign transfer_error_flag = ter_reg;
endmodule

/* File: dv/lds_spi_slave_properties.sv */
// Concurrent checks on the low-side diagnosis slave ports
module lds_chk
   import lds_pkg::*;
(
   // Clock and reset
   input wire logic                       clk,
   input wire logic                       arst_n,
   // Link pins
   input wire logic                       cs_n,
   input wire logic                       sdo_oe,
   // Channel and register views
   input wire logic [lds_pkg::NUM_CH-1:0] chan_on,
   input wire logic [lds_pkg::NUM_CH-1:0] diag_pulldown_current,
   input wire logic [7:0]                 input_reg_q,
   input wire logic [7:0]                 diag_reg_q,
   input wire logic                       transfer_error_flag
);
   // Two-bit mask per channel whose mode field equals c
   function automatic logic [7:0] m(logic [7:0] r, logic [1:0] c);
      for (int i = 0; i < 4; i++)
         m[2*i+:2] = {2{r[2*i+:2] == c}};
   endfunction
   // Fault bits of the diagnosis word, one per channel
   function automatic logic [3:0] f4(logic [7:0] d);
      f4 = {d[6], d[4], d[2], d[0]};
   endfunction
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Lengths allow for the two-flop pin synchroniser
   idle_oe_a: assert property (cs_n [*6] |-> !sdo_oe)
      else $error("data out driven while deselected");
   sel_oe_a: assert property (!cs_n [*8] |-> sdo_oe)
      else $error("data out released while selected");
   pd_mode_a: assert property ($stable(input_reg_q) [*2] |->
      diag_pulldown_current == f4(~m(input_reg_q, MODE_IDLE)))
      else $error("pull-down does not follow mode");
   idle_off_a: assert property ($stable(input_reg_q) [*2] |->
      (chan_on & f4(m(input_reg_q, MODE_IDLE) | m(input_reg_q, MODE_OFF)))
      == 4'h0)
      else $error("channel on in idle or off mode");
   idle_clr_a: assert property ($stable(input_reg_q) [*2] |->
      (diag_reg_q & m(input_reg_q, MODE_IDLE)) == 8'h00)
      else $error("flag held in idle mode");
   flag_latch_a: assert property (($past(diag_reg_q) & ~diag_reg_q
      & ~m(input_reg_q, MODE_IDLE)
      & ~m($past(input_reg_q), MODE_IDLE)) == 8'h00)
      else $error("flag dropped outside idle mode");
   on_no_ol_a: assert property ((diag_reg_q & ~$past(diag_reg_q)
      & 8'hAA & m(input_reg_q, MODE_ON)
      & m($past(input_reg_q), MODE_ON)) == 8'h00)
      else $error("open load flagged while on");
   fault_off_a: assert property ((chan_on & f4(diag_reg_q)
      & f4($past(diag_reg_q))) == 4'h0)
      else $error("faulted channel still on");
   ter_rst_a: assert property ($rose(arst_n) |-> transfer_error_flag)
      else $error("error flag clear after reset");
endmodule
bind lds_spi_slave lds_chk i_lds_chk (.clk, .arst_n, .cs_n, .sdo_oe,
   .chan_on, .diag_pulldown_current, .input_reg_q, .diag_reg_q,
   .transfer_error_flag);

/* File: dv/lds_host.sv */
// Host serial master model facing the slave link pins
module lds_host (
   // Clock
   input wire logic clk,
   // Link pins
   output logic     cs_n,
   output logic     sclk,
   output logic     sdi,
   input wire logic sdo,
   input wire logic sdo_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_q; // Last level seen on the data-out wire
   // Released wire reads inverted, never a stale copy
   wire  so = sdo_oe ? sdo : ~last_q;
   always @(posedge clk) if (sdo_oe) last_q <= sdo;
   initial begin
      cs_n = 1; sclk = 0; sdi = 0; last_q = 0;
   end
   task automatic wt(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // One frame of n clocks; 320 ns link period, idle-low clock
   task automatic xfer(input int n, input logic [15:0] tx,
                       input logic p, output logic [15:0] rx,
                       output logic pre);
      rx = 16'h0000;
      sdi = p;
      wt(1);
      cs_n = 0; // Clock low at select edges
      wt(5);
      pre = so;
      for (int i = n - 1; i >= 0; i--) begin
         sdi = tx[i]; // Most significant first, one per clock
         sclk = 1;
         wt(4);
         rx = {rx[14:0], so};
         sclk = 0;
         wt(4);
      end
      cs_n = 1; // Every frame ends with select rising
      wt(6);
   endtask
   // Clock and data toggled with select high
   task automatic noise;
      repeat (8) begin
         sclk = ~sclk; sdi = ~sdi; wt(4);
      end
   endtask
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for the low-side diagnosis serial slave
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import lds_pkg::*;
   // Clock, reset and channel stimulus
   logic        clk = 0;
   logic        arst_n = 0;
   logic  [3:0] chan_in = 0, open_load_det = 0;
   logic  [3:0] overload_det = 0, overtemp_det = 0;
   // Link and observed outputs
   wire         cs_n, sclk, sdi, sdo, sdo_oe, transfer_error_flag;
   wire   [3:0] chan_on, diag_pulldown_current;
   wire   [7:0] input_reg_q, diag_reg_q;
   // Scores and transfer results
   int          fail_count = 0;
   int          checks_done = 0;
   logic [15:0] rx;
   logic        pre;
   always #20 clk = ~clk;
   lds_spi_slave i_lds_spi_slave (.clk, .arst_n, .cs_n, .sclk, .sdi, .sdo,
      .sdo_oe, .chan_in, .open_load_det, .overload_det, .overtemp_det,
      .chan_on, .diag_pulldown_current, .input_reg_q, .diag_reg_q,
      .transfer_error_flag);
   lds_host i_lds_host (.clk, .cs_n, .sclk, .sdi, .sdo, .sdo_oe);
   task automatic chk(input logic [15:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic wt(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(logic [7:0] w);
      i_lds_host.xfer(8, {8'h00, w}, 1'b0, rx, pre);
   endtask
   task automatic print_verdict;
      if (fail_count == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Values straight after reset
   task automatic t_reset;
      chk(input_reg_q, INPUT_RST);
      chk(diag_reg_q, DIAG_RST);
      chk({transfer_error_flag, sdo_oe}, 2'b10);
      chk({chan_on, diag_pulldown_current}, 8'h00);
   endtask
   // First write: error bit up front, mode fields placed
   task automatic t_write;
      chan_in = 4'h4;
      wr(8'h1B);
      chk(pre, 1'b1);
      chk(rx, 16'h0000);
      chk({input_reg_q, transfer_error_flag}, 9'h036);
      chk(diag_pulldown_current, 4'h7);
      chk(chan_on, 4'h6);
   endtask
   // Two-byte pass-through, empty and odd counts refused
   task automatic t_count;
      i_lds_host.xfer(16, 16'hA53C, 1'b0, rx, pre);
      chk(rx, 16'h00A5);
      chk(input_reg_q, 8'h3C);
      i_lds_host.xfer(0, 16'h0000, 1'b0, rx, pre);
      chk({input_reg_q, transfer_error_flag}, 9'h079);
      wr(8'h1B);
      i_lds_host.xfer(7, 16'h0055, 1'b1, rx, pre);
      chk(pre, 1'b1);
      chk({input_reg_q, transfer_error_flag}, 9'h037);
      i_lds_host.noise;
      chk({input_reg_q, sdo_oe, transfer_error_flag}, 10'h06D);
   endtask
   // Open load, overload, overtemperature, then clear
   task automatic t_diag;
      chan_in = 4'h0;
      wr(8'hDB);
      open_load_det = 4'hF;
      wt(100);
      open_load_det = 4'h0;
      wt(10);
      chk(diag_reg_q, 8'h00);
      open_load_det = 4'hF;
      wt(800);
      open_load_det = 4'h0;
      wt(10);
      chk(diag_reg_q, 8'hA2);
      overload_det = 4'h2;
      wt(100);
      chk(chan_on, 4'h2);
      wt(100);
      overload_det = 4'h0;
      wt(10);
      chk({chan_on, diag_reg_q}, 12'h0A6);
      overtemp_det = 4'h8;
      wt(10);
      overtemp_det = 4'h0;
      i_lds_host.xfer(8, 16'h00DB, 1'b0, rx, pre);
      chk(rx, 16'h00E6);
      wr(8'h00);
      chk({diag_reg_q, diag_pulldown_current}, 12'h000);
      wr(8'hDB);
      chk(chan_on, 4'h2);
      // Direct channel driven high must not gather open load
      chan_in = 4'h4;
      open_load_det = 4'hF;
      wt(800);
      open_load_det = 4'h0;
      wt(10);
      chk({chan_on, diag_reg_q}, 12'h682);
   endtask
   // Reset in mid-run: registers cleared, error flag raised again
   task automatic t_rerst;
      arst_n = 0;
      wt(2);
      chk({chan_on, diag_reg_q, transfer_error_flag}, 13'h0001);
      arst_n = 1;
      wt(6);
      chk({input_reg_q, diag_reg_q}, 16'h0000);
      wr(8'h1B);
      chk({pre, input_reg_q, transfer_error_flag}, 10'h236);
   endtask
   initial begin
      wt(8);
      arst_n = 1;
      wt(6);
      t_reset;
      t_write;
      t_count;
      t_diag;
      t_rerst;
      print_verdict;
   end
   // Whole run needs about 110 us
   initial begin
      #500us;
      fail_count++;
      print_verdict;
   end
endmodule
